/* File: rtl/pfsi_core.sv */
// fault status, sticky flags, fault record, alert pin and power-disable delay
// assumes supply comparator levels arrive as asynchronous pins
//
// Decided for this implementation: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/100ps
module pfsi_core
  import pfsi_pkg::*;
#(
  parameter int HALF_MS_CYC = pfsi_pkg::PFSI_HALF_MS_CYC
)(
  input  wire logic                       clk_i,
  input  wire logic                       rst_i,
  input  wire logic                       wb_cyc_i,
  input  wire logic                       wb_stb_i,
  input  wire logic                       wb_we_i,
  input  wire logic [7:0]                 wb_adr_i,
  input  wire logic [3:0]                 wb_sel_i,
  input  wire logic [31:0]                wb_dat_i,
  output logic      [31:0]                wb_dat_o,
  output logic                            wb_ack_o,
  input  wire logic                       uvlo_ok_i,
  input  wire logic                       supply_monitor_ok_i,
  input  wire logic                       supply_low_warning_i,
  input  wire logic                       supply_high_warning_i,
  input  wire logic                       supply_overvoltage_trip_i,
  input  wire logic                       over_temperature_i,
  input  wire logic                       system_reset_out_n_i,
  input  wire logic [pfsi_pkg::PFSI_RAILS-1:0] power_good_i,
  input  wire logic [pfsi_pkg::PFSI_RAILS-1:0] rail_power_bad_i,
  input  wire logic                       power_disable_input_i,
  output logic                            run_o,
  output logic                            fault_alert_n_o,
  output logic                            fault_alert_n_oe_o,
  output logic                            irq_o
);
  import pfsi_pkg::*;

  localparam int NS = 6 + PFSI_RAILS * 2 + 1;

  ////////////////////////////////////////////////////////////////////////////
  // synchronisers
  logic [NS-1:0] raw, s1, s2;
  assign raw = {power_disable_input_i, rail_power_bad_i, power_good_i, system_reset_out_n_i,
                over_temperature_i, supply_overvoltage_trip_i, supply_high_warning_i,
                supply_low_warning_i, supply_monitor_ok_i};
  logic uv1, uv2;
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s1  <= '0;
      s2  <= '0;
      uv1 <= 1'b0;
      uv2 <= 1'b0;
    end
    else
    begin
      s1  <= raw;
      s2  <= s1;
      uv1 <= uvlo_ok_i;
      uv2 <= uv1;
    end
  end

  logic                  mon_ok, low_ok, high_w, ovt, ovtrip, rst_n_s, dis_s;
  logic [PFSI_RAILS-1:0] pg_s, rail_power_bad_s;
  assign {dis_s, rail_power_bad_s, pg_s, rst_n_s, ovt, ovtrip, high_w, low_ok, mon_ok} = s2;

  ////////////////////////////////////////////////////////////////////////////
  // live status and sticky flags
  logic [PFSI_TOP_W-1:0] top;
  logic [PFSI_RAILS-1:0] rail_power_bad_flag, next_rail_power_bad_flag, rail_power_bad_q;
  logic [PFSI_REC_W-1:0] rec, next_rec, mask, next_mask, src, src_q;
  logic [2:0]            dly_sel, next_dly_sel;
  logic                  alert;

  always_comb
  begin
    top                = '0;
    top[PFSI_B_MON]    = mon_ok;
    top[PFSI_B_WARN]   = low_ok;
    top[PFSI_B_HIGH]   = high_w;
    top[PFSI_B_OVT]    = ovt;
    top[PFSI_B_OVTRIP] = ovtrip;
    top[PFSI_B_RST]    = rst_n_s;
    top[PFSI_B_ALERT]  = alert;
  end

  // fault sources are active-high: low warning, monitor loss, reset and power-good invert
  assign src = {rail_power_bad_flag, ~pg_s, alert_free_top(top)};

  function automatic logic [PFSI_TOP_W-1:0] alert_free_top(input logic [PFSI_TOP_W-1:0] t);
    logic [PFSI_TOP_W-1:0] f;
    f                = '0;
    f[PFSI_B_MON]    = ~t[PFSI_B_MON];
    f[PFSI_B_WARN]   = ~t[PFSI_B_WARN];
    f[PFSI_B_HIGH]   = t[PFSI_B_HIGH];
    f[PFSI_B_OVT]    = t[PFSI_B_OVT];
    f[PFSI_B_OVTRIP] = t[PFSI_B_OVTRIP];
    f[PFSI_B_RST]    = ~t[PFSI_B_RST];
    alert_free_top   = f;
  endfunction : alert_free_top

  ////////////////////////////////////////////////////////////////////////////
  // bus decode
  logic acc, wr, rd, ack, next_ack;
  logic [31:0] rdat, next_rdat;
  assign acc = wb_cyc_i && wb_stb_i && !ack;
  assign wr  = acc && wb_we_i && wb_sel_i[0];
  assign rd  = acc && !wb_we_i;

  always_comb
  begin
    next_rail_power_bad_flag = rail_power_bad_flag;
    for (int i = 0; i < PFSI_RAILS; i++)
    begin
      if (rd && wb_adr_i == PFSI_ADR_FLAG && !rail_power_bad_s[i])
        next_rail_power_bad_flag[i] = 1'b0;
      if (rail_power_bad_s[i] && !rail_power_bad_q[i])
        next_rail_power_bad_flag[i] = 1'b1;  // set wins over read clear
    end
    next_rec = rec;
    if (wr && wb_adr_i == PFSI_ADR_CLEAR)
      next_rec = rec & ~wb_dat_i[PFSI_REC_W-1:0];
    next_rec = next_rec | (src & ~src_q);  // edge set wins over clear
    if (!uv2)
      next_rec = '0;
    next_mask = mask;
    if (wr && wb_adr_i == PFSI_ADR_MASK)
      next_mask = wb_dat_i[PFSI_REC_W-1:0];
    next_dly_sel = dly_sel;
    if (wr && wb_adr_i == PFSI_ADR_POWER_DISABLE_INPUT)
      next_dly_sel = wb_dat_i[2:0];
    next_ack  = acc;
    next_rdat = '0;
    case (wb_adr_i)
      PFSI_ADR_TOP:    next_rdat[PFSI_TOP_W-1:0] = top;
      PFSI_ADR_FLAG:   next_rdat[PFSI_RAILS-1:0] = rail_power_bad_flag;
      PFSI_ADR_RAIL:   next_rdat[PFSI_RAILS-1:0] = pg_s;
      PFSI_ADR_CLEAR:  next_rdat[PFSI_REC_W-1:0] = rec;
      PFSI_ADR_MASK:   next_rdat[PFSI_REC_W-1:0] = mask;
      PFSI_ADR_POWER_DISABLE_INPUT: next_rdat[2:0] = dly_sel;
      PFSI_ADR_STATE:  next_rdat[1:0] = {run_o, dis_s};
      default:         next_rdat = '0;
    endcase
    if (!rd)
      next_rdat = wb_dat_o;
  end

  // fault record and masks survive disable; lockout clears the record, masks keep their value
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rail_power_bad_flag <= '0;
      rail_power_bad_q    <= '0;
      rec       <= '0;
      src_q     <= '0;
      mask      <= '0;
      dly_sel   <= PFSI_DLY_RESET;
      ack       <= 1'b0;
      wb_dat_o  <= '0;
    end
    else
    begin
      rail_power_bad_flag <= next_rail_power_bad_flag;
      rail_power_bad_q    <= rail_power_bad_s;
      rec       <= next_rec;
      src_q     <= src;
      mask      <= next_mask;
      dly_sel   <= next_dly_sel;  // no reload on disable release
      ack       <= next_ack;
      wb_dat_o  <= next_rdat;
    end
  end
  assign wb_ack_o = ack;

  ////////////////////////////////////////////////////////////////////////////
  // alert pin, open drain
  assign alert              = |(rec & ~mask);
  assign fault_alert_n_o    = 1'b0;
  assign fault_alert_n_oe_o = ~alert;  // oe low drives pin low
  assign irq_o              = alert;

  ////////////////////////////////////////////////////////////////////////////
  // power state and disable delay
  pfsi_state_e state, next_state;
  logic [31:0] cnt, next_cnt, dly_cyc;
  logic        dis_act;

  assign dly_cyc = (dly_sel == 3'h0) ? 32'h0 : 32'(HALF_MS_CYC) << (dly_sel - 3'h1);
  assign dis_act = dis_s && (dly_sel != PFSI_DLY_IGNORE);

  always_comb
  begin
    next_state = state;
    next_cnt   = cnt;
    case (state)
      PFSI_OFF:
        if (mon_ok && uv2 && !ovtrip && !dis_act)
          next_state = PFSI_ON;
      PFSI_ON:
        if (!uv2 || ovtrip)
          next_state = PFSI_OFF;  // warnings ignored here
        else if (dis_act)
        begin
          next_state = PFSI_DELAY;
          next_cnt   = '0;
        end
      PFSI_DELAY:
        if (!uv2 || ovtrip)
          next_state = PFSI_OFF;
        else if (!dis_act)
          next_state = PFSI_ON;
        else if (cnt >= dly_cyc)
          next_state = PFSI_OFF;
        else
          next_cnt = cnt + 32'h1;
      default:
        next_state = PFSI_OFF;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state <= PFSI_OFF;
      cnt   <= '0;
    end
    else
    begin
      state <= next_state;
      cnt   <= next_cnt;
    end
  end
  assign run_o = (state != PFSI_OFF);

  ////////////////////////////////////////////////////////////////////////////
  // checks
  property p_lockout_off;
    @(posedge clk_i) disable iff (rst_i) !uv2 |=> !run_o;
  endproperty
  a_lockout_off: assert property (p_lockout_off) else $error("run after lockout");

  property p_ovtrip_off;
    @(posedge clk_i) disable iff (rst_i) ovtrip |=> !run_o;
  endproperty
  a_ovtrip_off: assert property (p_ovtrip_off) else $error("run after overvoltage");

  property p_start_mon;
    @(posedge clk_i) disable iff (rst_i) $rose(run_o) |-> $past(mon_ok);
  endproperty
  a_start_mon: assert property (p_start_mon) else $error("start below monitor");

  property p_warn_keeps;
    @(posedge clk_i) disable iff (rst_i) (run_o && uv2 && !ovtrip && !dis_act && !low_ok) |=> run_o;
  endproperty
  a_warn_keeps: assert property (p_warn_keeps) else $error("warning shut down");

  property p_ignore;
    @(posedge clk_i) disable iff (rst_i) (dly_sel == PFSI_DLY_IGNORE) |-> state != PFSI_DELAY;
  endproperty
  a_ignore: assert property (p_ignore) else $error("disable not ignored");

  property p_rail_power_bad_sticky;
    @(posedge clk_i) disable iff (rst_i) (rail_power_bad_flag[0] && !(rd && wb_adr_i == PFSI_ADR_FLAG)) |=> rail_power_bad_flag[0];
  endproperty
  a_rail_power_bad_sticky: assert property (p_rail_power_bad_sticky) else $error("power-bad flag lost");

  property p_rec_sticky;
    @(posedge clk_i) disable iff (rst_i) (rec[0] && uv2 && !(wr && wb_adr_i == PFSI_ADR_CLEAR)) |=> rec[0];
  endproperty
  a_rec_sticky: assert property (p_rec_sticky) else $error("record lost");

  property p_alert_mask;
    @(posedge clk_i) disable iff (rst_i) ((rec & ~mask) == '0) |-> fault_alert_n_oe_o;
  endproperty
  a_alert_mask: assert property (p_alert_mask) else $error("masked fault alerts");

  property p_alert_low;
    @(posedge clk_i) disable iff (rst_i) (rec[1] && !mask[1]) |-> !fault_alert_n_oe_o;
  endproperty
  a_alert_low: assert property (p_alert_low) else $error("alert not low");

  ////////////////////////////////////////////////////////////////////////////
  // bus, live status and record checks
  property p_ack_pulse;
    @(posedge clk_i) disable iff (rst_i) wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");

  property p_ack_follows;
    @(posedge clk_i) disable iff (rst_i) (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o;
  endproperty
  a_ack_follows: assert property (p_ack_follows) else $error("request not acknowledged");

  property p_live_mon;
    @(posedge clk_i) disable iff (rst_i) (rd && wb_adr_i == PFSI_ADR_TOP) |=> wb_dat_o[PFSI_B_MON] == $past(mon_ok);
  endproperty
  a_live_mon: assert property (p_live_mon) else $error("monitor bit not live");

  property p_live_rail;
    @(posedge clk_i) disable iff (rst_i) (rd && wb_adr_i == PFSI_ADR_RAIL) |=> wb_dat_o[PFSI_RAILS-1:0] == $past(pg_s);
  endproperty
  a_live_rail: assert property (p_live_rail) else $error("power-good bits not live");

  property p_rail_power_bad_set;
    @(posedge clk_i) disable iff (rst_i) (rail_power_bad_s[0] && !rail_power_bad_q[0]) |=> rail_power_bad_flag[0];
  endproperty
  a_rail_power_bad_set: assert property (p_rail_power_bad_set) else $error("power-bad edge not flagged");

  property p_rail_power_bad_read_clr;
    @(posedge clk_i) disable iff (rst_i) (rd && wb_adr_i == PFSI_ADR_FLAG && !rail_power_bad_s[0]) |=> !rail_power_bad_flag[0];
  endproperty
  a_rail_power_bad_read_clr: assert property (p_rail_power_bad_read_clr) else $error("gone flag kept after read");

  property p_flag_read_val;
    @(posedge clk_i) disable iff (rst_i)
      (rd && wb_adr_i == PFSI_ADR_FLAG) |=> wb_dat_o[PFSI_RAILS-1:0] == $past(rail_power_bad_flag);
  endproperty
  a_flag_read_val: assert property (p_flag_read_val) else $error("flag read not latched value");

  property p_rec_edge;
    @(posedge clk_i) disable iff (rst_i) (src[1] && !src_q[1] && uv2) |=> rec[1];
  endproperty
  a_rec_edge: assert property (p_rec_edge) else $error("status edge not recorded");

  property p_rec_rail_power_bad;
    @(posedge clk_i) disable iff (rst_i)
      (rail_power_bad_flag[0] && !src_q[PFSI_TOP_W+PFSI_RAILS] && uv2) |=> rec[PFSI_TOP_W+PFSI_RAILS];
  endproperty
  a_rec_rail_power_bad: assert property (p_rec_rail_power_bad) else $error("flag edge not recorded");

  property p_rec_clear;
    @(posedge clk_i) disable iff (rst_i)
      (wr && wb_adr_i == PFSI_ADR_CLEAR && wb_dat_i[0] && !(src[0] && !src_q[0])) |=> !rec[0];
  endproperty
  a_rec_clear: assert property (p_rec_clear) else $error("record not cleared");

  property p_rec_lockout;
    @(posedge clk_i) disable iff (rst_i) !uv2 |=> rec == '0;
  endproperty
  a_rec_lockout: assert property (p_rec_lockout) else $error("record kept in lockout");

  property p_alert_any;
    @(posedge clk_i) disable iff (rst_i) ((rec & ~mask) != '0) |-> irq_o;
  endproperty
  a_alert_any: assert property (p_alert_any) else $error("unmasked record without irq");

  property p_warn_alert;
    @(posedge clk_i) disable iff (rst_i)
      (src[PFSI_B_WARN] && !src_q[PFSI_B_WARN] && uv2 && !mask[PFSI_B_WARN] &&
       !(wr && wb_adr_i == PFSI_ADR_MASK)) |=> irq_o;
  endproperty
  a_warn_alert: assert property (p_warn_alert) else $error("low warning not alerted");

  ////////////////////////////////////////////////////////////////////////////
  // power state checks
  property p_start_up;
    @(posedge clk_i) disable iff (rst_i) (!run_o && mon_ok && uv2 && !ovtrip && !dis_act) |=> run_o;
  endproperty
  a_start_up: assert property (p_start_up) else $error("no start in normal range");

  property p_dis_down;
    @(posedge clk_i) disable iff (rst_i) (state == PFSI_ON && dis_act && uv2 && !ovtrip) |=> state == PFSI_DELAY;
  endproperty
  a_dis_down: assert property (p_dis_down) else $error("disable not taken");

  property p_release_up;
    @(posedge clk_i) disable iff (rst_i) (state == PFSI_DELAY && !dis_act && uv2 && !ovtrip) |=> state == PFSI_ON;
  endproperty
  a_release_up: assert property (p_release_up) else $error("release did not restart");

  property p_delay_hold;
    @(posedge clk_i) disable iff (rst_i)
      (state == PFSI_DELAY && dis_act && uv2 && !ovtrip && cnt < dly_cyc) |=> run_o;
  endproperty
  a_delay_hold: assert property (p_delay_hold) else $error("off before delay ran out");

  property p_zero_dly;
    @(posedge clk_i) disable iff (rst_i)
      (state == PFSI_DELAY && dly_sel == 3'h0 && dis_act && uv2 && !ovtrip) |=> !run_o;
  endproperty
  a_zero_dly: assert property (p_zero_dly) else $error("zero delay not immediate");

  property p_ignore_dis;
    @(posedge clk_i) disable iff (rst_i) (dly_sel == PFSI_DLY_IGNORE && run_o && uv2 && !ovtrip) |=> run_o;
  endproperty
  a_ignore_dis: assert property (p_ignore_dis) else $error("ignored disable shut down");

  property p_dly_keep;
    @(posedge clk_i) disable iff (rst_i) !(wr && wb_adr_i == PFSI_ADR_POWER_DISABLE_INPUT) |=> $stable(dly_sel);
  endproperty
  a_dly_keep: assert property (p_dly_keep) else $error("delay select changed unasked");
endmodule : pfsi_core

/* File: rtl/pfsi_pkg.sv */
// constants for the fault status and alert block
// assumes a classic wishbone slave with 32-bit data, byte addresses
// Contract
// - run only above supply monitor threshold; code checks it only to start, not while running
// - supply warnings can raise the alert
// - warnings alone never force shutdown
// - undervoltage lockout or overvoltage forces shutdown
// - live status bits follow sources directly
// - live bit reads one while condition true
// - power-bad flag sets on edge, stays
// - read returns latched, then clears if gone
// - fault record captures status and flags
// - host writes one to clear record
// - record holds until cleared or lockout
// - masked record does not affect alert
// - unmasked record drives alert pin low
// - disable high powers down, low powers up
// - disable falling edge never reloads fuse defaults
// - power-off delay 0 to 16 ms selectable
// - delay select seven ignores disable input
package pfsi_pkg;
  localparam int          PFSI_RAILS        = 6;
  localparam int          PFSI_TOP_W        = 7;
  localparam int          PFSI_REC_W        = PFSI_TOP_W + 2 * PFSI_RAILS;
  localparam logic [7:0]  PFSI_ADR_TOP      = 8'h00;
  localparam logic [7:0]  PFSI_ADR_FLAG     = 8'h04;
  localparam logic [7:0]  PFSI_ADR_RAIL     = 8'h0c;
  localparam logic [7:0]  PFSI_ADR_CLEAR    = 8'h48;
  localparam logic [7:0]  PFSI_ADR_MASK     = 8'h4c;
  localparam logic [7:0]  PFSI_ADR_POWER_DISABLE_INPUT   = 8'he4;
  localparam logic [7:0]  PFSI_ADR_STATE    = 8'hfc;
  // top status bit positions
  localparam int          PFSI_B_MON        = 0;
  localparam int          PFSI_B_WARN       = 1;
  localparam int          PFSI_B_HIGH       = 2;
  localparam int          PFSI_B_OVT        = 3;
  localparam int          PFSI_B_OVTRIP     = 4;
  localparam int          PFSI_B_RST        = 5;
  localparam int          PFSI_B_ALERT      = 6;
  localparam logic [2:0]  PFSI_DLY_IGNORE   = 3'h7;
  localparam logic [2:0]  PFSI_DLY_RESET    = 3'h0;
  localparam int          PFSI_CLK_MHZ      = 200;
  localparam int          PFSI_HALF_MS_US   = 500;
  localparam int          PFSI_HALF_MS_CYC  = PFSI_HALF_MS_US * PFSI_CLK_MHZ;
  typedef enum logic [1:0] {PFSI_OFF, PFSI_ON, PFSI_DELAY} pfsi_state_e;
endpackage : pfsi_pkg

/* File: test/pfsi_host_model.sv */
// host-side model: drives the power-disable pin, watches the open-drain alert line
// assumes one clock shared with the block; disable requests come from the bench
`timescale 1ns/100ps
module pfsi_host_model (
  input  wire logic clk_i,
  input  wire logic dis_req_i,
  input  wire logic fault_alert_n_i,
  input  wire logic fault_alert_n_oe_i,
  output logic      power_disable_input_o,
  output logic      alert_seen_o
);
  logic alert_wire_n;
  // board pull-up holds the line high while released
  assign alert_wire_n = fault_alert_n_oe_i ? 1'b1 : fault_alert_n_i;
  assign alert_seen_o = ~alert_wire_n;
  initial power_disable_input_o = 1'b0;
  always @(posedge clk_i)
    power_disable_input_o <= dis_req_i;
endmodule : pfsi_host_model

/* File: test/test_pfsi_core.sv */
// self-checking bench for the fault status and alert block
// assumes HALF_MS_CYC shortened to 10 so every delay code fits the run
`timescale 1ns/100ps
module test_pfsi_core;
  import pfsi_pkg::*;
  localparam int HALF = 10;
  logic        clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, dis_req = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] dat = 32'h0, rdat, rng = 32'h0001_0075;
  logic        uvlo = 1'b1, mon = 1'b0, lw = 1'b1, hw = 1'b0, ovt = 1'b0, ot = 1'b0, hot = 1'b0;
  logic [5:0]  pg = 6'h3f, rail_power_bad = 6'h00, lost = 6'h00;
  logic        ack, run, an, aoe, irq, dis, alert;
  logic [63:0] exp_q[$];
  int          err_total = 0, check_count = 0, cyc_n = 0;
  always #2.5 clk_i = ~clk_i;
  pfsi_core #(.HALF_MS_CYC(HALF)) pfsi_core_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .uvlo_ok_i(uvlo), .supply_monitor_ok_i(mon), .supply_low_warning_i(lw), .supply_high_warning_i(hw),
    .supply_overvoltage_trip_i(ovt), .over_temperature_i(ot), .system_reset_out_n_i(1'b1),
    .power_good_i(pg), .rail_power_bad_i(rail_power_bad), .power_disable_input_i(dis), .run_o(run),
    .fault_alert_n_o(an), .fault_alert_n_oe_o(aoe), .irq_o(irq));
  pfsi_host_model pfsi_host_model_inst (.clk_i(clk_i), .dis_req_i(dis_req), .fault_alert_n_i(an),
    .fault_alert_n_oe_i(aoe), .power_disable_input_o(dis), .alert_seen_o(alert));
  //////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] m);
    check_count++;
    if ((got & m) !== (exp & m))
    begin
      err_total++;
      $display("unexpected at %0t: got %h want %h", $time, got & m, exp & m);
    end
  endtask : cmp
  task automatic bit_is(input logic got, input logic exp);
    cmp({31'h0, got}, {31'h0, exp}, 32'h1);
  endtask : bit_is
  task automatic conclude;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude
  // read notes carry a nonzero mask; write notes carry zero and are skipped
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] m);
    int n;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= d;
    exp_q.push_back({m, d});
    n = 0;
    @(posedge clk_i);
    while (ack !== 1'b1 && n < 50)
    begin
      n++;
      @(posedge clk_i);
    end
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n == 50)
      cmp(32'h0, 32'h1, 32'h1);
  endtask : bus
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    bus(1'b0, a, e, m);
  endtask : rd
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 32'h0);
  endtask : wr
  task automatic wait_cyc(input int k);
    repeat (k) @(posedge clk_i);
  endtask : wait_cyc
  //////////////////////////////////////////////////////////////////////////////
  always @(posedge clk_i)
  begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 30000)
    begin
      err_total++;
      conclude();
    end
    if (ack === 1'b1 && exp_q.size() > 0)
    begin
      if (exp_q[0][63:32] != 32'h0)
        cmp(rdat, exp_q[0][31:0], exp_q[0][63:32]);
      void'(exp_q.pop_front());
    end
  end
  initial
  begin
    int d, n;
    wait_cyc(3);
    rst_i <= 1'b0;
    wait_cyc(8);
    bit_is(run, 1'b0);
    mon <= 1'b1;
    wait_cyc(5);
    bit_is(run, 1'b1);
    wr(PFSI_ADR_CLEAR, 32'h0007_ffff);
    wr(PFSI_ADR_MASK, 32'h0);
    wr(8'h80, 32'hffff_ffff);
    rd(8'h80, 32'h0, 32'hffff_ffff);
    rd(PFSI_ADR_TOP, 32'h0000_0023, 32'h0000_003f);
    $display("test idle done");
    for (int i = 0; i < 4; i++)
    begin
      rng = xs(rng);
      pg <= rng[5:0];
      ot <= rng[6];
      lost = lost | ~rng[5:0];
      hot = hot | rng[6];
      wait_cyc(5);
      rd(PFSI_ADR_RAIL, {26'h0, rng[5:0]}, 32'h0000_003f);
      rd(PFSI_ADR_TOP, {28'h0, rng[6], 3'h3}, 32'h0000_000f);
    end
    pg <= 6'h3f;
    ot <= 1'b0;
    wait_cyc(5);
    rd(PFSI_ADR_CLEAR, {19'h0, lost, 3'h0, hot, 3'h0}, 32'h0000_1f88);
    bit_is(irq, |{lost, hot});
    wr(PFSI_ADR_CLEAR, 32'h0007_ffff);
    rd(PFSI_ADR_CLEAR, 32'h0, 32'h0007_ffff);
    $display("test live done");
    rail_power_bad <= 6'h04;
    wait_cyc(5);
    rail_power_bad <= 6'h20;
    wait_cyc(5);
    rd(PFSI_ADR_FLAG, 32'h24, 32'h3f);
    rd(PFSI_ADR_FLAG, 32'h20, 32'h3f);
    rd(PFSI_ADR_CLEAR, 32'h0004_8000, 32'h0007_e000);
    wr(PFSI_ADR_MASK, 32'h0007_ffff);
    wait_cyc(3);
    bit_is(irq, 1'b0);
    bit_is(alert, 1'b0);
    wr(PFSI_ADR_MASK, 32'h0);
    wait_cyc(3);
    bit_is(irq, 1'b1);
    bit_is(alert, 1'b1);
    rail_power_bad <= 6'h00;
    wait_cyc(5);
    rd(PFSI_ADR_FLAG, 32'h20, 32'h3f);
    rd(PFSI_ADR_FLAG, 32'h00, 32'h3f);
    wr(PFSI_ADR_CLEAR, 32'h0007_ffff);
    wait_cyc(3);
    bit_is(alert, 1'b0);
    $display("test flags done");
    for (int c = 0; c < 8; c++)
    begin
      wr(PFSI_ADR_POWER_DISABLE_INPUT, {29'h0, c[2:0]});
      d = (c == 0 || c == 7) ? 0 : HALF << (c - 1);
      dis_req <= 1'b1;
      n = 0;
      while (run === 1'b1 && n < 400)
      begin
        n++;
        @(posedge clk_i);
      end
      bit_is(c == 7 ? n == 400 : (n >= d && n <= d + 8), 1'b1);
      dis_req <= 1'b0;
      wait_cyc(6);
      bit_is(run, 1'b1);
      rd(PFSI_ADR_POWER_DISABLE_INPUT, {29'h0, c[2:0]}, 32'h7);
    end
    $display("test delay done");
    lw <= 1'b0;
    hw <= 1'b1;
    wait_cyc(5);
    bit_is(run, 1'b1);
    rd(PFSI_ADR_CLEAR, 32'h6, 32'h6);
    bit_is(alert, 1'b1);
    ovt <= 1'b1;
    wait_cyc(5);
    bit_is(run, 1'b0);
    uvlo <= 1'b0;
    ovt <= 1'b0;
    wait_cyc(5);
    bit_is(run, 1'b0);
    uvlo <= 1'b1;
    wait_cyc(5);
    rd(PFSI_ADR_CLEAR, 32'h0, 32'h16);
    $display("test supply done");
    conclude();
  end
endmodule : test_pfsi_core
